// [rst_wdt_pkg.sv]
/*
 * Constants, register map and carrier types for the system reset and
 * watchdog block. Assumes a single 250 MHz bus clock and AHB-Lite access.
 */
package rst_wdt_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] OFS_CAUSE = 12'h000;
  localparam logic [11:0] OFS_WDT   = 12'h004;
  localparam logic [11:0] OFS_STAT  = 12'h008;

  // Reset cause register bit positions
  localparam int POS_POR  = 0;
  localparam int POS_EXT  = 1;
  localparam int POS_BOR  = 2;
  localparam int POS_WDR  = 3;
  localparam int POS_SCAN = 4;

  // Watchdog control register bit positions
  localparam int POS_WDP  = 0;
  localparam int POS_WDE  = 3;
  localparam int POS_WATCHDOG_CHANGE_ENABLE_BIT = 4;
  localparam int POS_RESTART = 5;

  // Status register bit positions
  localparam int POS_LEVEL  = 0;
  localparam int POS_VREF   = 2;
  localparam int POS_BODLVL = 3;

  localparam logic [4:0] CAUSE_RESET = 5'h00;
  localparam logic [2:0] WDP_RESET   = 3'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ       = 250;
  localparam int WDT_OSC_MHZ   = 1;
  localparam int WDT_OSC_DIV   = CLK_MHZ / WDT_OSC_MHZ;
  localparam int WIN_CLOCKS    = 4;
  localparam int BOD_MIN_NS    = 2000;
  localparam int BOD_MIN_CYC   = (BOD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int WDT_BASE_CYC  = 16384;
  localparam int WDT_CNT_W     = 22;
  localparam int DLY_CNT_W     = 24;

  // Safety levels
  typedef enum logic [1:0] {
    LEVEL0 = 2'b00,
    LEVEL1 = 2'b01,
    LEVEL2 = 2'b10
  } safety_type;

  // Fuse bundle
  typedef struct packed {
    logic [3:0] clock_source_fuses;
    logic [1:0] startup_time_fuses;
    logic       brownout_level_fuse;
    logic       brownout_enable_fuse;
    logic       compat_mode_fuse;
    logic       watchdog_always_on_fuse;
  } fuses_type;

  // Analog and scan reset indications
  typedef struct packed {
    logic power_low;
    logic brownout_low;
    logic scan_reset;
  } sources_type;

endpackage : rst_wdt_pkg

// [system_reset_and_watchdog.sv]
/*
 * System reset controller and watchdog timer. Fuses are programmed
 * when a bit is one. Analog detectors and the pin arrive asynchronously.
 * The watchdog oscillator is modelled as an enable from a divider.
 */
`timescale 1ns/100ps
module system_reset_and_watchdog #(
  parameter logic [23:0] DLY_UNIT = 24'h000040
) (
  // Bus clock and power-on reset
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [11:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  // Fuses and reset sources
  input  wire rst_wdt_pkg::fuses_type   fuses,
  input  wire rst_wdt_pkg::sources_type sources,
  input  wire logic                     ext_reset_n,
  input  wire logic                     converter_enable,
  input  wire logic                     comparator_bandgap_select,
  // Outputs
  output logic                          core_reset_n,
  output logic                          port_reset_n,
  output logic                          vref_enable,
  output logic                          brownout_level_high
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0] ext_s_r, pwr_s_r, bod_s_r, scan_s_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s_r  <= 3'h7;
      pwr_s_r  <= 3'h0;
      bod_s_r  <= 3'h0;
      scan_s_r <= 3'h0;
    end else begin
      ext_s_r  <= {ext_s_r[1:0], ext_reset_n};
      pwr_s_r  <= {pwr_s_r[1:0], sources.power_low};
      bod_s_r  <= {bod_s_r[1:0], sources.brownout_low};
      scan_s_r <= {scan_s_r[1:0], sources.scan_reset};
    end
  end

  logic ext_low_r, pwr_low_r, bod_raw_r, scan_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_low_r <= 1'b0;
      pwr_low_r <= 1'b0;
      bod_raw_r <= 1'b0;
      scan_r    <= 1'b0;
    end else begin
      if (ext_s_r[1] == ext_s_r[2]) ext_low_r <= ~ext_s_r[2];
      if (pwr_s_r[1] == pwr_s_r[2]) pwr_low_r <= pwr_s_r[2];
      if (bod_s_r[1] == bod_s_r[2]) bod_raw_r <= bod_s_r[2];
      if (scan_s_r[1] == scan_s_r[2]) scan_r <= scan_s_r[2];
    end
  end

  // ****************************************************************
  // Brown-out filter
  // ****************************************************************
  logic [9:0] bod_cnt_r;
  logic       bod_low_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bod_cnt_r <= 10'h000;
      bod_low_r <= 1'b0;
    end else if (!bod_raw_r || !fuses.brownout_enable_fuse) begin
      bod_cnt_r <= 10'h000;
      bod_low_r <= 1'b0;
    end else if (bod_cnt_r >= 10'(rst_wdt_pkg::BOD_MIN_CYC)) begin
      bod_low_r <= 1'b1;
    end else begin
      bod_cnt_r <= bod_cnt_r + 10'h001;
    end
  end

  // ****************************************************************
  // Source combination and delay counter
  // ****************************************************************
  logic wdt_pulse_r;
  logic any_src;
  assign any_src = pwr_low_r | ext_low_r | bod_low_r | scan_r | wdt_pulse_r;

  logic [23:0] dly_cnt_r;
  logic [23:0] dly_len;
  assign dly_len = DLY_UNIT * {18'h00000, fuses.startup_time_fuses,
                               fuses.clock_source_fuses};

  logic chip_rst_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_cnt_r  <= 24'h000000;
      chip_rst_r <= 1'b1;
    end else if (any_src) begin
      dly_cnt_r  <= 24'h000000;
      chip_rst_r <= 1'b1;
    end else if (dly_cnt_r < dly_len) begin
      dly_cnt_r <= dly_cnt_r + 24'h000001;
    end else begin
      chip_rst_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) core_reset_n <= 1'b0;
    else          core_reset_n <= ~chip_rst_r;
  end

  logic port_async_n;
  assign port_async_n = hresetn & ext_reset_n & ~sources.power_low;
  always_ff @(posedge hclk or negedge port_async_n) begin
    if (!port_async_n) port_reset_n <= 1'b0;
    else               port_reset_n <= ~chip_rst_r & ~any_src;
  end

  // ****************************************************************
  // Safety level and reference
  // ****************************************************************
  rst_wdt_pkg::safety_type level;
  always_comb begin
    case ({fuses.compat_mode_fuse, fuses.watchdog_always_on_fuse})
      2'b00:   level = rst_wdt_pkg::LEVEL1;
      2'b10:   level = rst_wdt_pkg::LEVEL0;
      default: level = rst_wdt_pkg::LEVEL2;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vref_enable         <= 1'b0;
      brownout_level_high <= 1'b0;
    end else begin
      vref_enable <= fuses.brownout_enable_fuse | comparator_bandgap_select
                     | converter_enable;
      brownout_level_high <= fuses.brownout_level_fuse;
    end
  end

  // ****************************************************************
  // AHB-Lite slave, zero wait states
  // ****************************************************************
  logic        wr_pend_r;
  logic [11:0] addr_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 12'h000;
    end else if (hready) begin
      wr_pend_r <= hsel & htrans[1] & hwrite;
      addr_r    <= haddr;
    end
  end
  logic wr_cause, wr_wdt;
  assign wr_cause = wr_pend_r && addr_r == rst_wdt_pkg::OFS_CAUSE;
  assign wr_wdt   = wr_pend_r && addr_r == rst_wdt_pkg::OFS_WDT;

  // ****************************************************************
  // Watchdog control
  // ****************************************************************
  logic       wde_r, watchdog_change_enable_bit_r;
  logic [2:0] wdp_r;
  logic [2:0] win_r;
  logic       wr_wde, wr_watchdog_change_enable_bit, wr_restart;
  logic [2:0] wr_wdp;
  assign wr_wde     = hwdata[rst_wdt_pkg::POS_WDE];
  assign wr_watchdog_change_enable_bit    = hwdata[rst_wdt_pkg::POS_WATCHDOG_CHANGE_ENABLE_BIT];
  assign wr_restart = hwdata[rst_wdt_pkg::POS_RESTART];
  assign wr_wdp     = hwdata[rst_wdt_pkg::POS_WDP +: 3];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wde_r  <= 1'b0;
      watchdog_change_enable_bit_r <= 1'b0;
      wdp_r  <= rst_wdt_pkg::WDP_RESET;
      win_r  <= 3'h0;
    end else if (chip_rst_r) begin
      wde_r  <= (level == rst_wdt_pkg::LEVEL2);
      watchdog_change_enable_bit_r <= 1'b0;
      wdp_r  <= rst_wdt_pkg::WDP_RESET;
      win_r  <= 3'h0;
    end else if (wr_wdt && wr_watchdog_change_enable_bit && wr_wde) begin
      watchdog_change_enable_bit_r <= 1'b1;
      win_r  <= 3'(rst_wdt_pkg::WIN_CLOCKS);
      wde_r  <= 1'b1;
      if (level == rst_wdt_pkg::LEVEL0) wdp_r <= wr_wdp;
    end else begin
      if (win_r != 3'h0) win_r <= win_r - 3'h1;
      if (win_r == 3'h1) watchdog_change_enable_bit_r <= 1'b0;
      if (wr_wdt) begin
        if (wr_wde) wde_r <= 1'b1;
        else if (watchdog_change_enable_bit_r && level != rst_wdt_pkg::LEVEL2) wde_r <= 1'b0;
        if (watchdog_change_enable_bit_r || level == rst_wdt_pkg::LEVEL0) wdp_r <= wr_wdp;
        if (watchdog_change_enable_bit_r) begin
          watchdog_change_enable_bit_r <= 1'b0;
          win_r  <= 3'h0;
        end
      end
      if (level == rst_wdt_pkg::LEVEL2) wde_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Watchdog counter on oscillator enable
  // ****************************************************************
  logic [7:0] osc_div_r;
  logic       osc_tick;
  assign osc_tick = (osc_div_r == 8'(rst_wdt_pkg::WDT_OSC_DIV - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)      osc_div_r <= 8'h00;
    else if (osc_tick) osc_div_r <= 8'h00;
    else               osc_div_r <= osc_div_r + 8'h01;
  end

  logic [rst_wdt_pkg::WDT_CNT_W-1:0] wdt_cnt_r;
  logic [rst_wdt_pkg::WDT_CNT_W-1:0] wdt_limit;
  assign wdt_limit = rst_wdt_pkg::WDT_CNT_W'(rst_wdt_pkg::WDT_BASE_CYC) << wdp_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_cnt_r   <= '0;
      wdt_pulse_r <= 1'b0;
    end else if (chip_rst_r || !wde_r ||
                 (wr_wdt && wr_restart)) begin
      wdt_cnt_r   <= '0;
      wdt_pulse_r <= 1'b0;
    end else if (osc_tick && wdt_cnt_r == wdt_limit - 1'b1) begin
      wdt_cnt_r   <= '0;
      wdt_pulse_r <= 1'b1;
    end else begin
      wdt_pulse_r <= 1'b0;
      if (osc_tick) wdt_cnt_r <= wdt_cnt_r + 1'b1;
    end
  end

  // ****************************************************************
  // Reset cause flags
  // ****************************************************************
  logic [4:0] cause_r;
  logic [4:0] cause_set;
  assign cause_set = {scan_r, wdt_pulse_r, bod_low_r, ext_low_r, pwr_low_r};
  // set wins over write-zero; power-on clears others
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_r <= rst_wdt_pkg::CAUSE_RESET | 5'h01;
    end else if (pwr_low_r) begin
      cause_r <= 5'h01;
    end else if (wr_cause) begin
      cause_r <= (cause_r & hwdata[4:0]) | cause_set;
    end else begin
      cause_r <= cause_r | cause_set;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr)
        rst_wdt_pkg::OFS_CAUSE: hrdata <= {27'h0, cause_r};
        rst_wdt_pkg::OFS_WDT:   hrdata <= {27'h0, watchdog_change_enable_bit_r, wde_r, wdp_r};
        rst_wdt_pkg::OFS_STAT:  hrdata <= {28'h0, brownout_level_high,
                                           vref_enable, level};
        default:                hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule : system_reset_and_watchdog

// [rst_wdt_checker_assertions.sv]
/* Assertions on the reset and watchdog block ports.
   Bound onto the top module; sees its ports only. */
`timescale 1ns/100ps
module rst_wdt_checker #(
  parameter logic [23:0] DLY_UNIT = 24'h000040
) (
  // Clock and reset
  input wire logic                     hclk,
  input wire logic                     hresetn,
  // Fuses and sources
  input wire rst_wdt_pkg::fuses_type   fuses,
  input wire rst_wdt_pkg::sources_type sources,
  input wire logic                     ext_reset_n,
  input wire logic                     converter_enable,
  input wire logic                     comparator_bandgap_select,
  // Watched outputs
  input wire logic                     core_reset_n,
  input wire logic                     port_reset_n,
  input wire logic                     vref_enable,
  input wire logic                     brownout_level_high
);
  // ****
  // Helpers
  // ****
  int   quiet;
  int   bod_run;
  int   dly;
  logic ref_src;
  assign dly = int'(DLY_UNIT) * int'({fuses.startup_time_fuses,
                                       fuses.clock_source_fuses});
  assign ref_src = fuses.brownout_enable_fuse | converter_enable
                 | comparator_bandgap_select;
  // Brown-out left out: a filtered dip must not restart the count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet <= 0;
    end else if (!ext_reset_n || sources.power_low
                 || sources.scan_reset) begin
      quiet <= 0;
    end else if (quiet < 1000000) begin
      quiet <= quiet + 1;
    end
  end
  // Saturates so it cannot wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bod_run <= 0;
    end else if (!sources.brownout_low) begin
      bod_run <= 0;
    end else if (bod_run < 1000000) begin
      bod_run <= bod_run + 1;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ****
  // Properties
  // ****
  AST_PORT_ASYNC: assert property (
    !ext_reset_n || sources.power_low |-> !port_reset_n)
    else $error("port reset idle under a source");
  AST_EXT_HOLD: assert property (
    !ext_reset_n [*8] |-> !core_reset_n)
    else $error("long pin pulse gave no reset");
  AST_POR_NOW: assert property (
    sources.power_low |-> ##[0:8] !core_reset_n)
    else $error("power low reset late");
  AST_SCAN_HOLD: assert property (
    sources.scan_reset && !core_reset_n |=> !core_reset_n)
    else $error("reset dropped under scan reset");
  AST_STRETCH: assert property (
    $rose(core_reset_n) |-> quiet >= dly)
    else $error("reset released before delay");
  AST_BOD_FILTER: assert property (
    $fell(core_reset_n) && sources.brownout_low && quiet > 16
    |-> fuses.brownout_enable_fuse && bod_run >= 496)
    else $error("brown-out reset unfiltered");
  AST_VREF: assert property (
    hresetn && $stable(ref_src) |=> vref_enable == $past(ref_src))
    else $error("reference enable wrong");
  AST_LEVEL: assert property (
    (hresetn && $stable(fuses.brownout_level_fuse)) [*2]
    |-> brownout_level_high == fuses.brownout_level_fuse)
    else $error("brown-out level wrong");
  C_RELEASE: cover property ($rose(core_reset_n));
  C_BOD: cover property ($fell(core_reset_n) && sources.brownout_low);
  C_SCAN: cover property (sources.scan_reset && !core_reset_n);
endmodule : rst_wdt_checker

bind system_reset_and_watchdog rst_wdt_checker #(.DLY_UNIT(DLY_UNIT))
  u_chk (.hclk, .hresetn, .fuses, .sources, .ext_reset_n,
         .converter_enable, .comparator_bandgap_select, .core_reset_n,
         .port_reset_n, .vref_enable, .brownout_level_high);

// [rst_far_side.sv]
/* Far-side model: reset pin driver and supply monitors.
   Assumes tasks are called right after a rising clock edge. */
`timescale 1ns/100ps
module rst_far_side #(
  parameter int MIN_PIN = 8
) (
  // Clock
  input  wire logic                hclk,
  // Pin and monitor levels
  output logic                     ext_reset_n,
  output rst_wdt_pkg::sources_type sources
);
  // Pin rests high on its pull-up
  initial begin
    ext_reset_n = 1'b1;
    sources     = '0;
  end
  // ****
  // Source pulses
  // ****
  // pin held for at least the minimum
  task automatic hold(input int which, input int cycles);
    int len;
    len = (which == 0 && cycles < MIN_PIN) ? MIN_PIN : cycles;
    @(posedge hclk);
    drive(which, 1'b1);
    repeat (len) @(posedge hclk);
    drive(which, 1'b0);
  endtask : hold
  task automatic drive(input int which, input logic on);
    case (which)
      0: ext_reset_n <= !on;
      1: sources.power_low <= on;
      2: sources.brownout_low <= on;
      default: sources.scan_reset <= on;
    endcase
  endtask : drive
endmodule : rst_far_side

// [testbench.sv]
/* Bench for the reset and watchdog block, one task a scenario.
   Assumes the far-side model and the bound checker. */
`timescale 1ns/100ps
module testbench;
  localparam logic [23:0] UNIT = 24'h000004;
  localparam int          DLY  = int'(UNIT) * 3;
  localparam logic [11:0] CAU  = rst_wdt_pkg::OFS_CAUSE;
  localparam logic [11:0] WDT  = rst_wdt_pkg::OFS_WDT;
  localparam logic [11:0] STA  = rst_wdt_pkg::OFS_STAT;
  logic                     hclk;
  logic                     hresetn;
  logic                     hsel;
  logic                     hwrite;
  logic [1:0]               htrans;
  logic [11:0]              haddr;
  logic [31:0]              hwdata;
  logic [31:0]              hrdata;
  logic                     hreadyout;
  logic                     hresp;
  rst_wdt_pkg::fuses_type   fuses;
  rst_wdt_pkg::sources_type sources;
  logic                     ext_reset_n;
  logic                     converter_enable;
  logic                     comparator_bandgap_select;
  logic                     core_reset_n;
  logic                     port_reset_n;
  logic                     vref_enable;
  logic                     brownout_level_high;
  logic [31:0]              q;
  int                       n;
  int                       n_errors;
  int                       samples_checked;
  int                       cycles;
  system_reset_and_watchdog #(.DLY_UNIT(UNIT)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .fuses, .sources, .ext_reset_n, .converter_enable,
    .comparator_bandgap_select, .core_reset_n, .port_reset_n,
    .vref_enable, .brownout_level_high);
  rst_far_side far (.hclk, .ext_reset_n, .sources);
  always #2 hclk = ~hclk;
  // Cuts a hang short
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // ****
  // Bus and compare tasks
  // ****
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk1("hresp", 1'b0, hresp);
  endtask : bus
  task automatic chk(input string s, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic chk1(input string s, input logic e, g);
    chk(s, {31'h0, e}, {31'h0, g});
  endtask : chk1
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("read", e, q);
  endtask : rd
  // Counts from a source release until the core leaves reset
  task automatic stretch();
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (core_reset_n !== 1'b1 && n < 3000);
    @(posedge hclk);
    chk1("stretch", 1'b1, n >= DLY && n <= DLY + 30);
  endtask : stretch
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    @(negedge hclk);
    chk1("core", 1'b0, core_reset_n);
    chk1("port", 1'b0, port_reset_n);
    chk("hrdata", 32'h0, hrdata);
    @(posedge hclk);
    hresetn <= 1'b1;
    stretch();
  endtask : do_reset
  // Port pins must drop before any further clock edge
  task automatic async_pulse(input int which, input int len);
    fork
      far.hold(which, len);
    join_none
    @(posedge hclk);
    #1;
    chk1("port", 1'b0, port_reset_n);
    wait fork;
    stretch();
  endtask : async_pulse
  // ****
  // Scenarios
  // ****
  task automatic t_wdt();
    rd(WDT, 32'h0);
    bus(1'b1, WDT, 32'h08);
    rd(WDT, 32'h08);
    bus(1'b1, WDT, 32'h01);
    bus(1'b1, WDT, 32'h00);
    rd(WDT, 32'h08);
    bus(1'b1, WDT, 32'h18);
    bus(1'b1, WDT, 32'h03);
    rd(WDT, 32'h03);
    bus(1'b1, WDT, 32'h0B);
    bus(1'b1, WDT, 32'h1B);
    repeat (8) @(posedge hclk);
    rd(WDT, 32'h0B);
    bus(1'b1, WDT, 32'h00);
    rd(WDT, 32'h0B);
    bus(1'b1, WDT, 32'h2B);
    rd(WDT, 32'h0B);
  endtask : t_wdt
  task automatic t_bod();
    far.hold(2, 600);
    chk1("core", 1'b1, core_reset_n);
    fuses.brownout_enable_fuse <= 1'b1;
    far.hold(2, 100);
    repeat (10) @(posedge hclk);
    chk1("core", 1'b1, core_reset_n);
    rd(CAU, 32'h0);
    far.hold(2, 600);
    stretch();
    rd(CAU, 32'h4);
  endtask : t_bod
  task automatic t_static();
    for (int i = 0; i < 8; i++) begin
      fuses.brownout_enable_fuse <= i[0];
      fuses.brownout_level_fuse <= i[0];
      comparator_bandgap_select <= i[1];
      converter_enable <= i[2];
      repeat (3) @(posedge hclk);
      chk1("vref", |i[2:0], vref_enable);
      chk1("bodlvl", i[0], brownout_level_high);
    end
    rd(STA, 32'hD);
  endtask : t_static
  task automatic t_levels();
    for (int j = 0; j < 4; j++) begin
      fuses.compat_mode_fuse <= j[0];
      fuses.watchdog_always_on_fuse <= j[1];
      do_reset();
      rd(STA, 32'hC | (j[1] ? 32'h2 : {31'h0, !j[0]}));
      rd(WDT, {28'h0, j[1], 3'h0});
      bus(1'b1, WDT, 32'h01);
      rd(WDT, j[1] ? 32'h8 : {31'h0, j[0]});
    end
  endtask : t_levels
  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 12'h000;
    hwdata = 32'h0;
    fuses = '{clock_source_fuses: 4'h3, default: '0};
    converter_enable = 1'b0;
    comparator_bandgap_select = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    cycles = 0;
    do_reset();
    rd(CAU, 32'h1);
    bus(1'b1, 12'h00C, 32'hFFFFFFFF);
    rd(12'h00C, 32'h0);
    bus(1'b1, CAU, 32'h0);
    rd(CAU, 32'h0);
    t_wdt();
    async_pulse(0, 20);
    rd(CAU, 32'h2);
    bus(1'b1, CAU, 32'h0);
    t_bod();
    t_static();
    far.hold(3, 300);
    stretch();
    rd(CAU, 32'h14);
    async_pulse(1, 30);
    rd(CAU, 32'h1);
    t_levels();
    report_and_stop();
  end
endmodule : testbench
